/* shared/htt_defs.vh */
// Register offsets, field positions and reset values of the tracking and trim bank
`ifndef HTT_DEFS_VH
`define HTT_DEFS_VH
`define HTT_ADDR_W         8
`define HTT_OFS_AVG_H      8'h44
`define HTT_OFS_AVG_L      8'h45
`define HTT_OFS_ACT_H      8'h46
`define HTT_OFS_ACT_L      8'h47
`define HTT_OFS_PHASE_H    8'h48
`define HTT_OFS_PHASE_L    8'h49
`define HTT_OFS_TRACKING_CONTROL    8'h4C
`define HTT_OFS_TRIM_LOOP  8'h5F
`define HTT_OFS_TRIM_FILT  8'h60
`define HTT_OFS_TRIM_EDGE  8'h62
`define HTT_OFS_TOP_CFG5   8'h6E
`define HTT_OFS_EVT_ACT    8'h81
`define HTT_OFS_STATUS2    8'h82
`define HTT_OFS_MASK2      8'h83
`define HTT_OFS_SNP_FIRST  8'h84
`define HTT_OFS_SNP_LAST   8'hE7
`define HTT_SNP_DEPTH      100
`define HTT_RST_ACT_H      8'h21
`define HTT_RST_ACT_L      7'h4F
`define HTT_RST_PHASE_H    8'h25
`define HTT_RST_SHIFT_L    3'h5
`define HTT_RST_FREEZE     1'b0
`define HTT_RST_AUTO_ADJ   1'b1
`define HTT_RST_FORCE_ON   1'b0
`define HTT_RST_UNDERVOLTAGE_LOCKOUT       2'h1
`define HTT_RST_CAP_TRIM   2'h3
`define HTT_RST_RES_TRIM   2'h0
`define HTT_RST_SLEW       2'h3
`define HTT_RST_V2I_OFS    1'b1
`define HTT_BIT_FREEZE     7
`define HTT_BIT_AUTO_ADJ   1
`define HTT_BIT_FORCE_ON   0
`define HTT_BIT_IDAC_X2    6
`define HTT_BIT_NARROW_BW  5
`define HTT_BIT_BYPASS     2
`define HTT_BIT_HOLD_REV   1
`define HTT_BIT_V2I_OFS    0
`define HTT_BIT_SAT_EVT    2
`define HTT_BIT_SAT_STA    7
`define HTT_BIT_SAT_MASK   7
`endif

/* verilog/htt_regs.v */
// Tracking, trim, fault and snippet memory register bank
`timescale 1ns/1ps
`default_nettype none
`include "htt_defs.vh"

// Summary of operation
// - Average period low seven bits read only, from last four half periods.
// - Period equals (high*128 + low) times 1333.32e-9 milliseconds.
// - Actual period readback, high resets 0x21, low seven bits reset 0x4F.
// - Autoscale bit enables proportional gain scaling; resets to one.
// - Force-on bit keeps tracking active beyond 25 % error; resets off.
// - Undervoltage select codes 0..3 mean 2.7..3.0 V; resets to 01.
// - Current DAC double range and narrow band filter bits reset zero.
// - Capacitor trim resets 3, resistor trim resets 0, both writable.
// - Low and high side slew fields 25..100 mV/ns, reset 3.
// - Delay comparator bypass bit, writable, resets zero.
// - Hold-on-reversal bit suspends frequency updates on polarity reversal.
// - Offset enable bit adds 50 mV offset to V2I factor; resets on.
// - Saturation event latches on saturated result; write one clears.
// - Saturation status bit reflects the fault condition, reset zero.
// - Saturation mask bit writable, resets zero.
// - Snippet bytes read-write, consecutive addresses, each resets zero.
// - Snippet memory holds 100 bytes at 0x84 through 0xE7.
module htt_regs (
   input  wire       clk,                            // 100 MHz clock
   input  wire       rst,                            // Async reset, active high
   input  wire       reg_wr,                         // Write strobe
   input  wire       reg_rd,                         // Read strobe
   input  wire [7:0] reg_addr,                       // Register address
   input  wire [7:0] reg_wdata,                      // Write data
   output reg  [7:0] reg_rdata,                      // Read data, valid cycle after reg_rd
   input  wire       period_load,                    // Tracking loop has new periods
   input  wire [7:0] avg_period_high_in,             // Averaged period high byte
   input  wire [6:0] avg_period_low_in,              // Averaged period low bits
   input  wire [7:0] actual_period_high_in,          // Half-period high byte
   input  wire [6:0] actual_period_low_in,           // Half-period low bits
   input  wire       converter_saturated,            // Converter result saturated
   output reg  [7:0] phase_delay_high,               // Phase delay high byte
   output reg        delay_freeze,                   // Delay freeze
   output reg  [2:0] delay_shift_low,                // Delay shift low field
   output reg        tracking_gain_autoscale,        // Scale proportional gain
   output reg        tracking_forced_active,         // Keep tracking on large error
   output reg        loop_current_dac_range_x2,      // Loop DAC double range
   output reg        loop_filter_narrow_band,        // Loop filter low bandwidth
   output reg  [1:0] undervoltage_threshold_select,  // 2.7/2.8/2.9/3.0 V
   output reg  [1:0] loop_capacitor_trim,            // Loop capacitor trim
   output reg  [1:0] loop_resistor_trim,             // Loop resistor trim
   output reg  [1:0] low_side_slew_select,           // Low side edge rate
   output reg  [1:0] high_side_slew_select,          // High side edge rate
   output reg        delay_comparator_bypass,        // Bypass delay comparator
   output reg        freq_hold_on_reversal,          // Pause updates on reversal
   output reg        volt_to_current_offset_enable,  // Add 50 mV V2I offset
   output reg        irq_r                           // Interrupt request
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register map
   // 0x44        [7:0] averaged period high byte, read only
   // 0x45        [6:0] averaged period low bits, read only
   // 0x46        [7:0] half-period high byte, read only
   // 0x47        [6:0] half-period low bits, read only
   // 0x48        [7:0] phase delay high byte
   // 0x49        [7]   delay freeze
   //             [2:0] delay shift low field
   // 0x4C        [1]   tracking gain autoscale
   //             [0]   tracking forced active
   // 0x5F        [6]   loop current DAC double range
   //             [5]   loop filter narrow band
   //             [4:3] undervoltage threshold select
   // 0x60        [3:2] loop capacitor trim
   //             [1:0] loop resistor trim
   // 0x62        [3:2] low side slew select
   //             [1:0] high side slew select
   // 0x6E        [2]   delay comparator bypass
   //             [1]   frequency hold on reversal
   //             [0]   volt to current offset enable
   // 0x81        [2]   saturation event, write one clears
   // 0x82        [7]   saturation status, read only
   // 0x83        [7]   saturation mask
   // 0x84..0xE7  [7:0] snippet memory bytes

   ////////////////////////////////////////////////////////////////////////////////
   // State
   reg [7:0] avg_h_r;
   reg [6:0] avg_l_r;
   reg [7:0] act_h_r;
   reg [6:0] act_l_r;
   reg       sat_sync1_r;
   reg       sat_sync2_r;
   reg       sat_evt_r;
   reg       sat_sta_r;
   reg       sat_mask_r;
   reg [7:0] snp_mem [0:`HTT_SNP_DEPTH-1];
   reg [7:0] rdata_nxt;
   integer   i;

   // Address falls inside the snippet window
   function is_snp;
      input [7:0] a;
      begin
         is_snp = (a >= `HTT_OFS_SNP_FIRST) && (a <= `HTT_OFS_SNP_LAST);
      end
   endfunction

   // Snippet array index from a byte address
   function [6:0] snp_idx;
      input [7:0] a;
      reg   [7:0] d;
      begin
         d       = a - `HTT_OFS_SNP_FIRST;
         snp_idx = d[6:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Write decode
   wire wr_snp = reg_wr && is_snp(reg_addr);
   wire clr_evt = reg_wr && (reg_addr == `HTT_OFS_EVT_ACT) && reg_wdata[`HTT_BIT_SAT_EVT];

   ////////////////////////////////////////////////////////////////////////////////
   // Period readback
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         avg_h_r <= 8'h00;
         avg_l_r <= 7'h00;
         act_h_r <= `HTT_RST_ACT_H;
         act_l_r <= `HTT_RST_ACT_L;
      end else begin
         if (period_load) begin
            avg_h_r <= avg_period_high_in;
            avg_l_r <= avg_period_low_in;
            act_h_r <= actual_period_high_in;
            act_l_r <= actual_period_low_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Converter saturation synchroniser
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sat_sync1_r <= 1'b0;
         sat_sync2_r <= 1'b0;
      end else begin
         sat_sync1_r <= converter_saturated;
         sat_sync2_r <= sat_sync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Saturation event, status and interrupt
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sat_evt_r <= 1'b0;
         sat_sta_r <= 1'b0;
         irq_r     <= 1'b0;
      end else begin
         sat_sta_r <= sat_sync2_r;
         // Set wins over a clear in the same cycle
         if (sat_sync2_r)
            sat_evt_r <= 1'b1;
         else if (clr_evt)
            sat_evt_r <= 1'b0;
         irq_r <= (sat_evt_r | sat_sync2_r) & ~sat_mask_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Writable controls
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_delay_high              <= `HTT_RST_PHASE_H;
         delay_freeze                  <= `HTT_RST_FREEZE;
         delay_shift_low               <= `HTT_RST_SHIFT_L;
         tracking_gain_autoscale       <= `HTT_RST_AUTO_ADJ;
         tracking_forced_active        <= `HTT_RST_FORCE_ON;
         loop_current_dac_range_x2     <= 1'b0;
         loop_filter_narrow_band       <= 1'b0;
         undervoltage_threshold_select <= `HTT_RST_UNDERVOLTAGE_LOCKOUT;
         loop_capacitor_trim           <= `HTT_RST_CAP_TRIM;
         loop_resistor_trim            <= `HTT_RST_RES_TRIM;
         low_side_slew_select          <= `HTT_RST_SLEW;
         high_side_slew_select         <= `HTT_RST_SLEW;
         delay_comparator_bypass       <= 1'b0;
         freq_hold_on_reversal         <= 1'b0;
         volt_to_current_offset_enable <= `HTT_RST_V2I_OFS;
         sat_mask_r                    <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            `HTT_OFS_PHASE_H: begin
               phase_delay_high <= reg_wdata;
            end
            `HTT_OFS_PHASE_L: begin
               delay_freeze    <= reg_wdata[`HTT_BIT_FREEZE];
               delay_shift_low <= reg_wdata[2:0];
            end
            `HTT_OFS_TRACKING_CONTROL: begin
               tracking_gain_autoscale <= reg_wdata[`HTT_BIT_AUTO_ADJ];
               tracking_forced_active  <= reg_wdata[`HTT_BIT_FORCE_ON];
            end
            `HTT_OFS_TRIM_LOOP: begin
               loop_current_dac_range_x2     <= reg_wdata[`HTT_BIT_IDAC_X2];
               loop_filter_narrow_band       <= reg_wdata[`HTT_BIT_NARROW_BW];
               undervoltage_threshold_select <= reg_wdata[4:3];
            end
            `HTT_OFS_TRIM_FILT: begin
               loop_capacitor_trim <= reg_wdata[3:2];
               loop_resistor_trim  <= reg_wdata[1:0];
            end
            `HTT_OFS_TRIM_EDGE: begin
               low_side_slew_select  <= reg_wdata[3:2];
               high_side_slew_select <= reg_wdata[1:0];
            end
            `HTT_OFS_TOP_CFG5: begin
               delay_comparator_bypass       <= reg_wdata[`HTT_BIT_BYPASS];
               freq_hold_on_reversal         <= reg_wdata[`HTT_BIT_HOLD_REV];
               volt_to_current_offset_enable <= reg_wdata[`HTT_BIT_V2I_OFS];
            end
            `HTT_OFS_MASK2: begin
               sat_mask_r <= reg_wdata[`HTT_BIT_SAT_MASK];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Snippet memory
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < `HTT_SNP_DEPTH; i = i + 1)
            snp_mem[i] <= 8'h00;
      end else if (wr_snp) begin
         snp_mem[snp_idx(reg_addr)] <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path; period pairs combine as high*128 + low
   always @* begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         `HTT_OFS_AVG_H: begin
            rdata_nxt = avg_h_r;
         end
         `HTT_OFS_AVG_L: begin
            rdata_nxt = {1'b0, avg_l_r};
         end
         `HTT_OFS_ACT_H: begin
            rdata_nxt = act_h_r;
         end
         `HTT_OFS_ACT_L: begin
            rdata_nxt = {1'b0, act_l_r};
         end
         `HTT_OFS_PHASE_H: begin
            rdata_nxt = phase_delay_high;
         end
         `HTT_OFS_PHASE_L: begin
            rdata_nxt = {delay_freeze, 4'h0, delay_shift_low};
         end
         `HTT_OFS_TRACKING_CONTROL: begin
            rdata_nxt = {6'h00, tracking_gain_autoscale,
                         tracking_forced_active};
         end
         `HTT_OFS_TRIM_LOOP: begin
            rdata_nxt = {1'b0, loop_current_dac_range_x2,
                         loop_filter_narrow_band,
                         undervoltage_threshold_select, 3'h0};
         end
         `HTT_OFS_TRIM_FILT: begin
            rdata_nxt = {4'h0, loop_capacitor_trim, loop_resistor_trim};
         end
         `HTT_OFS_TRIM_EDGE: begin
            rdata_nxt = {4'h0, low_side_slew_select, high_side_slew_select};
         end
         `HTT_OFS_TOP_CFG5: begin
            rdata_nxt = {5'h00, delay_comparator_bypass,
                         freq_hold_on_reversal,
                         volt_to_current_offset_enable};
         end
         `HTT_OFS_EVT_ACT: begin
            rdata_nxt = {5'h00, sat_evt_r, 2'h0};
         end
         `HTT_OFS_STATUS2: begin
            rdata_nxt = {sat_sta_r, 7'h00};
         end
         `HTT_OFS_MASK2: begin
            rdata_nxt = {sat_mask_r, 7'h00};
         end
         default: begin
            if (is_snp(reg_addr))
               rdata_nxt = snp_mem[snp_idx(reg_addr)];
            else
               rdata_nxt = 8'h00;
         end
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rdata_nxt;
   end

endmodule
`default_nettype wire

/* test/htt_regs_assertions.sv */
// Concurrent checks on the tracking and trim register bank ports
`timescale 1ns/1ps
`default_nettype none
module htt_regs_checker (
   input wire logic       clk,                     // Clock
   input wire logic       rst,                     // Reset
   input wire logic       reg_wr,                  // Write
   input wire logic       reg_rd,                  // Read
   input wire logic [7:0] reg_addr,                // Address
   input wire logic [7:0] reg_wdata,               // Write data
   input wire logic [7:0] reg_rdata,               // Read data
   input wire logic       converter_saturated,     // Saturation in
   input wire logic       irq_r,                   // Interrupt
   input wire logic [7:0] phase_delay_high,        // Phase high
   input wire logic       delay_freeze,            // Freeze
   input wire logic [2:0] delay_shift_low,         // Shift low
   input wire logic       tracking_gain_autoscale, // Autoscale
   input wire logic       tracking_forced_active,  // Forced on
   input wire logic [1:0] loop_capacitor_trim,     // Cap trim
   input wire logic [1:0] loop_resistor_trim       // Res trim
);
   logic mask_r;
   ////////////////////////////////////////////////////////////////
   // Shadow of the saturation mask bit
   always @(posedge clk or posedge rst) begin
      if (rst)
         mask_r <= 1'b0;
      else if (reg_wr && reg_addr == 8'h83)
         mask_r <= reg_wdata[7];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence wr_at(a);
      reg_wr && reg_addr == a;
   endsequence
   sequence sat_seen;
      $rose(converter_saturated) ##1 (converter_saturated && !mask_r)[*5];
   endsequence
   AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   AST_PHASE_WR: assert property (wr_at(8'h48) |=> phase_delay_high == $past(reg_wdata))
      else $error("phase high not written");
   AST_SHIFT_WR: assert property (wr_at(8'h49) |=>
      {delay_freeze, delay_shift_low} == {$past(reg_wdata[7]), $past(reg_wdata[2:0])})
      else $error("phase low not written");
   AST_CTL_WR: assert property (wr_at(8'h4C) |=>
      {tracking_gain_autoscale, tracking_forced_active} == $past(reg_wdata[1:0]))
      else $error("tracking control not written");
   AST_FILT_WR: assert property (wr_at(8'h60) |=>
      {loop_capacitor_trim, loop_resistor_trim} == $past(reg_wdata[3:0]))
      else $error("filter trim not written");
   AST_IRQ_MASKED: assert property (mask_r && $past(mask_r) |-> !irq_r)
      else $error("interrupt while masked");
   AST_IRQ_RAISE: assert property (sat_seen |-> irq_r)
      else $error("interrupt missing on saturation");
   AST_IRQ_CAUSE: assert property ($rose(irq_r) |-> !$past(mask_r))
      else $error("interrupt rose under mask");
endmodule
bind htt_regs htt_regs_checker htt_regs_checker_i (.clk(clk), .rst(rst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .converter_saturated(converter_saturated), .irq_r(irq_r),
   .phase_delay_high(phase_delay_high), .delay_freeze(delay_freeze),
   .delay_shift_low(delay_shift_low), .tracking_gain_autoscale(tracking_gain_autoscale),
   .tracking_forced_active(tracking_forced_active),
   .loop_capacitor_trim(loop_capacitor_trim), .loop_resistor_trim(loop_resistor_trim));
`default_nettype wire

/* test/htt_regs_bench.sv */
// Self-checking bench for the tracking and trim register bank
`timescale 1ns/1ps
`default_nettype none
module htt_regs_bench;
   logic       clk, rst, reg_wr, reg_rd, period_load, converter_saturated;
   logic [7:0] reg_addr, reg_wdata, avg_h, act_h;
   logic [6:0] avg_l, act_l;
   wire  [7:0] reg_rdata, ph;
   wire  [2:0] sh;
   wire  [1:0] uv, cap, res, ls, hs;
   wire        fz, au, fo, x2, nb, by, ho, vo, irq_r;
   wire  [28:0] ctl = {ph, fz, sh, au, fo, x2, nb, uv, cap, res, ls, hs, by, ho, vo};
   int         failures, tests_run, i;
   logic [7:0] ra [16] = '{8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4C, 8'h5F,
                           8'h60, 8'h62, 8'h6E, 8'h81, 8'h82, 8'h83, 8'h84, 8'hE7};
   logic [7:0] rv [16] = '{8'h00, 8'h00, 8'h21, 8'h4F, 8'h25, 8'h05, 8'h02, 8'h08,
                           8'h0C, 8'h0F, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] wa [13] = '{8'h48, 8'h49, 8'h4C, 8'h5F, 8'h60, 8'h62, 8'h6E, 8'h84,
                           8'hE7, 8'h46, 8'h50, 8'hE8, 8'h82};
   logic [7:0] wd [13] = '{8'h00, 8'h85, 8'h01, 8'hFF, 8'h06, 8'h09, 8'h06, 8'hA5,
                           8'h5A, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0] we [13] = '{8'h00, 8'h85, 8'h01, 8'h78, 8'h06, 8'h09, 8'h06, 8'hA5,
                           8'h5A, 8'h21, 8'h00, 8'h00, 8'h00};
   htt_regs htt_regs_i (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .period_load(period_load), .avg_period_high_in(avg_h), .avg_period_low_in(avg_l),
      .actual_period_high_in(act_h), .actual_period_low_in(act_l),
      .converter_saturated(converter_saturated), .phase_delay_high(ph), .delay_freeze(fz),
      .delay_shift_low(sh), .tracking_gain_autoscale(au), .tracking_forced_active(fo),
      .loop_current_dac_range_x2(x2), .loop_filter_narrow_band(nb),
      .undervoltage_threshold_select(uv), .loop_capacitor_trim(cap),
      .loop_resistor_trim(res), .low_side_slew_select(ls), .high_side_slew_select(hs),
      .delay_comparator_bypass(by), .freq_hold_on_reversal(ho),
      .volt_to_current_offset_enable(vo), .irq_r(irq_r));
   ////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("Checks run %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk) #1;
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk) #1;
      reg_rd = 1'b0;
      chk(reg_rdata, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_irq;
      int n;
      n = 0;
      while (irq_r !== 1'b1 && n < 8) begin
         @(posedge clk) #1;
         n++;
      end
      chk(irq_r, 1);
      if (n == 8)
         wrap_up();
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst, reg_wr, reg_rd, period_load, converter_saturated} = 5'b1_0000;
      {reg_addr, reg_wdata, avg_h, act_h, avg_l, act_l} = '0;
      failures = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      chk(ctl, 32'h04AB_0E79);
      for (i = 0; i < 16; i++)
         rd(ra[i], rv[i]);
      for (i = 0; i < 13; i++)
         wr(wa[i], wd[i]);
      for (i = 0; i < 13; i++)
         rd(wa[i], we[i]);
      rd(8'h85, 8'h00);
      chk(ctl, 32'h001A_FB4E);
      avg_h = 8'h12;
      avg_l = 7'h34;
      act_h = 8'h56;
      act_l = 7'h78;
      period_load = 1'b1;
      idle(1);
      period_load = 1'b0;
      for (i = 0; i < 4; i++)
         rd(8'h44 + i[7:0], (i % 2) ? {1'b0, (i < 2) ? avg_l : act_l} : ((i < 2) ? avg_h : act_h));
      converter_saturated = 1'b1;
      wait_irq();
      rd(8'h81, 8'h04);
      rd(8'h82, 8'h80);
      converter_saturated = 1'b0;
      idle(6);
      chk(irq_r, 1);
      wr(8'h81, 8'h04);
      idle(3);
      chk(irq_r, 0);
      rd(8'h81, 8'h00);
      rd(8'h82, 8'h00);
      wr(8'h83, 8'h80);
      converter_saturated = 1'b1;
      idle(8);
      chk(irq_r, 0);
      rd(8'h81, 8'h04);
      rd(8'h83, 8'h80);
      converter_saturated = 1'b0;
      idle(3);
      wr(8'h81, 8'h04);
      wr(8'h83, 8'h00);
      idle(3);
      chk(irq_r, 0);
      wrap_up();
   end
endmodule
`default_nettype wire
